// >>> bench/host_model.sv
`timescale 1ns/1ps
module host_model
(
    // Register port
    input  wire logic       clk,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_write,
    output logic            reg_read
);
    initial {reg_addr, reg_wdata, reg_write, reg_read} = 18'h00000;
    // Released address and data show the inverse; both strobes drop to zero
    task automatic put(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(negedge clk);
        {reg_addr, reg_wdata, reg_write, reg_read} = {a, d, w, !w};
        @(negedge clk);
        {reg_addr, reg_wdata, reg_write, reg_read} = {~a, ~d, 2'h0};
    endtask
endmodule

// >>> bench/rtc_status_flag_register_sva.sv
`timescale 1ns/1ps
module rtc_status_flag_register_sva
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset,
    // Register port
    input  wire logic [7:0]           reg_addr,
    input  wire logic                 reg_write,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_read,
    input  wire status_pkg::byte_type reg_rdata,
    input  wire logic                 reg_rvalid,
    // Protection and core inputs
    input  wire logic                 write_protected,
    input  wire logic                 periodic_update_event,
    input  wire logic                 nvm_transfer_active,
    // Status copy
    input  wire status_pkg::byte_type flags
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence open_wr;
        reg_write && !write_protected && reg_addr == 8'h0e;
    endsequence
    AST_RVALID: assert property (reg_read |=> reg_rvalid) else $error("no answer");
    AST_UPDATE_SET:
        assert property (periodic_update_event |=> ##1 flags[4]) else $error("update not set");
    AST_WP:
        assert property (reg_write && write_protected ##1 flags[4] |=> flags[4]) else $error("wp");
    AST_KEEP:
        assert property (open_wr ##0 reg_wdata[4] ##1 flags[4] |=> flags[4]) else $error("one");
    AST_CLEAR:
        assert property (open_wr ##0 !reg_wdata[4] && !periodic_update_event |=> ##1 !flags[4])
            else $error("clr");
    AST_BUSY:
        assert property (!$past(reset) |-> flags[7] == $past(nvm_transfer_active))
            else $error("bsy");
    AST_POR: assert property ($fell(reset) |=> flags[0]) else $error("por");
    sequence status_rd;
        reg_read && reg_addr == 8'h0e;
    endsequence
    AST_RDATA:
        assert property (status_rd |=> reg_rdata == flags) else $error("read data off");
    AST_MISS:
        assert property (reg_read && reg_addr != 8'h0e |=> reg_rdata == 8'h00)
            else $error("miss read not zero");
endmodule
bind rtc_status_flag_register rtc_status_flag_register_sva chk
(
    .clk                   (clk),
    .reset                 (reset),
    .reg_addr              (reg_addr),
    .reg_write             (reg_write),
    .reg_wdata             (reg_wdata),
    .reg_read              (reg_read),
    .reg_rdata             (reg_rdata),
    .reg_rvalid            (reg_rvalid),
    .write_protected       (write_protected),
    .periodic_update_event (periodic_update_event),
    .nvm_transfer_active   (nvm_transfer_active),
    .flags                 (flags)
);

// >>> bench/rtc_status_flag_register_tb.sv
`timescale 1ns/1ps
module rtc_status_flag_register_tb;
    logic clk = 1'h0, reset = 1'h1, write_protected = 1'h0, nvm_transfer_active = 1'h0;
    logic [6:0] ev = 7'h00;
    logic clock_output_event, supply_switchover_event, periodic_update_event;
    logic countdown_expiry_event, alarm_match_event, external_event, power_loss_event;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, flags;
    logic reg_write, reg_read, reg_rvalid;
    int n_fail = 0, checks = 0;
    // Event pulses, write data, expected read
    logic [22:0] rows [4] = '{{7'h10, 8'hff, 8'h11}, {7'h00, 8'hef, 8'h01},
                              {7'h6e, 8'hfe, 8'h6e}, {7'h00, 8'h00, 8'h00}};
    assign {clock_output_event, supply_switchover_event, periodic_update_event,
            countdown_expiry_event, alarm_match_event, external_event, power_loss_event} = ev;
    always #2.5 clk = ~clk;
    host_model hm
    (
        .clk       (clk),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_write (reg_write),
        .reg_read  (reg_read)
    );
    rtc_status_flag_register DUT
    (
        .clk                     (clk),
        .reset                   (reset),
        .reg_addr                (reg_addr),
        .reg_write               (reg_write),
        .reg_wdata               (reg_wdata),
        .reg_read                (reg_read),
        .reg_rdata               (reg_rdata),
        .reg_rvalid              (reg_rvalid),
        .write_protected         (write_protected),
        .clock_output_event      (clock_output_event),
        .supply_switchover_event (supply_switchover_event),
        .periodic_update_event   (periodic_update_event),
        .countdown_expiry_event  (countdown_expiry_event),
        .alarm_match_event       (alarm_match_event),
        .external_event          (external_event),
        .power_loss_event        (power_loss_event),
        .nvm_transfer_active     (nvm_transfer_active),
        .flags                   (flags)
    );
    task automatic end_of_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        // Answer stands one cycle only: look right after the read edge
        hm.put(a, 8'h00, 1'h0);
        checks++;
        if (reg_rvalid !== 1'h1 || reg_rdata !== e)
        begin
            n_fail++;
            $display("mismatch %0t read %h want %h", $time, reg_rdata, e);
        end
        checks++;
        if (a == 8'h0e && flags !== e)
        begin
            n_fail++;
            $display("mismatch %0t status copy %h want %h", $time, flags, e);
        end
    endtask
    task automatic pulse(input logic [6:0] e);
        @(negedge clk);
        ev = e;
        @(negedge clk);
        ev = 7'h00;
    endtask
    initial
    begin
        repeat (10) @(negedge clk);
        reset = 1'h0;
        rd_chk(8'h0e, 8'h01);
        foreach (rows[i])
        begin
            pulse(rows[i][22:16]);
            hm.put(8'h0e, rows[i][15:8], 1'h1);
            rd_chk(8'h0e, rows[i][7:0]);
        end
        pulse(7'h10);
        write_protected = 1'h1;
        hm.put(8'h0e, 8'h00, 1'h1);
        nvm_transfer_active = 1'h1;
        rd_chk(8'h0e, 8'h90);
        write_protected = 1'h0;
        // Miss address: write dropped, read answers zero
        hm.put(8'h0f, 8'h00, 1'h1);
        rd_chk(8'h0f, 8'h00);
        rd_chk(8'h0e, 8'h90);
        // Event and clear in one cycle: the set wins
        fork
            pulse(7'h10);
            hm.put(8'h0e, 8'hef, 1'h1);
        join
        rd_chk(8'h0e, 8'h90);
        // Mid-run reset: outputs drop, then the power flag and the live busy bit come back
        reset = 1'h1;
        repeat (2) @(negedge clk);
        checks++;
        if (reg_rvalid !== 1'h0 || reg_rdata !== 8'h00 || flags !== 8'h00)
        begin
            n_fail++;
            $display("mismatch %0t outputs not cleared by reset", $time);
        end
        reset = 1'h0;
        rd_chk(8'h0e, 8'h81);
        end_of_test();
    end
endmodule

// >>> verilog/rtc_status_flag_register.sv
`timescale 1ns/1ps
`include "status_map.svh"

module rtc_status_flag_register
(
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset,
    // Register port
    input  wire logic [7:0]                reg_addr,
    input  wire logic                      reg_write,
    input  wire logic [7:0]                reg_wdata,
    input  wire logic                      reg_read,
    output status_pkg::byte_type           reg_rdata,
    output logic                           reg_rvalid,
    // Protection
    input  wire logic                      write_protected,
    // Event pulses and live busy level from core logic
    input  wire logic                      clock_output_event,
    input  wire logic                      supply_switchover_event,
    input  wire logic                      periodic_update_event,
    input  wire logic                      countdown_expiry_event,
    input  wire logic                      alarm_match_event,
    input  wire logic                      external_event,
    input  wire logic                      power_loss_event,
    input  wire logic                      nvm_transfer_active,
    // Flags for the interrupt logic
    output status_pkg::byte_type           flags
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    logic                 hit;
    logic                 write_ok;
    status_pkg::byte_type set_vec;
    status_pkg::byte_type clr_vec;
    status_pkg::byte_type rst_vec;
    status_pkg::byte_type flag_vec;

    assign hit      = (reg_addr == `EVENT_STATUS_FLAGS_ADDR);
    // A blocked write is dropped silently; the host sees no error
    assign write_ok = reg_write && hit && !write_protected;

    always_comb
    begin
        set_vec = `BYTE_ZERO;
        set_vec[`BIT_CLKOUT_FLAG] = clock_output_event;
        set_vec[`BIT_SWITCH_FLAG] = supply_switchover_event;
        set_vec[`BIT_UPDATE_FLAG] = periodic_update_event;
        set_vec[`BIT_TIMER_FLAG]  = countdown_expiry_event;
        set_vec[`BIT_ALARM_FLAG]  = alarm_match_event;
        set_vec[`BIT_EVENT_FLAG]  = external_event;
        set_vec[`BIT_POWER_FLAG]  = power_loss_event;
        // Only zero bits clear; ones leave flags alone
        clr_vec = write_ok ? ~reg_wdata : `BYTE_ZERO;
        // Power flag comes up set; event flag taken as clear at power-on
        rst_vec = `BYTE_ZERO;
        rst_vec[`BIT_POWER_FLAG] = `FLAG_SET;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky flags, bits 6..0
    // Separate instances so each flag keeps its own name in a trace

    sticky_flag u_clock_output_flag
    (
        .clk         (clk),
        .reset       (reset),
        .reset_value (rst_vec[`BIT_CLKOUT_FLAG]),
        .set_pulse   (set_vec[`BIT_CLKOUT_FLAG]),
        .clear_pulse (clr_vec[`BIT_CLKOUT_FLAG]),
        .flag        (flag_vec[`BIT_CLKOUT_FLAG])
    );

    sticky_flag u_switchover_flag
    (
        .clk         (clk),
        .reset       (reset),
        .reset_value (rst_vec[`BIT_SWITCH_FLAG]),
        .set_pulse   (set_vec[`BIT_SWITCH_FLAG]),
        .clear_pulse (clr_vec[`BIT_SWITCH_FLAG]),
        .flag        (flag_vec[`BIT_SWITCH_FLAG])
    );

    sticky_flag u_update_flag
    (
        .clk         (clk),
        .reset       (reset),
        .reset_value (rst_vec[`BIT_UPDATE_FLAG]),
        .set_pulse   (set_vec[`BIT_UPDATE_FLAG]),
        .clear_pulse (clr_vec[`BIT_UPDATE_FLAG]),
        .flag        (flag_vec[`BIT_UPDATE_FLAG])
    );

    sticky_flag u_countdown_flag
    (
        .clk         (clk),
        .reset       (reset),
        .reset_value (rst_vec[`BIT_TIMER_FLAG]),
        .set_pulse   (set_vec[`BIT_TIMER_FLAG]),
        .clear_pulse (clr_vec[`BIT_TIMER_FLAG]),
        .flag        (flag_vec[`BIT_TIMER_FLAG])
    );

    sticky_flag u_alarm_flag
    (
        .clk         (clk),
        .reset       (reset),
        .reset_value (rst_vec[`BIT_ALARM_FLAG]),
        .set_pulse   (set_vec[`BIT_ALARM_FLAG]),
        .clear_pulse (clr_vec[`BIT_ALARM_FLAG]),
        .flag        (flag_vec[`BIT_ALARM_FLAG])
    );

    sticky_flag u_external_flag
    (
        .clk         (clk),
        .reset       (reset),
        .reset_value (rst_vec[`BIT_EVENT_FLAG]),
        .set_pulse   (set_vec[`BIT_EVENT_FLAG]),
        .clear_pulse (clr_vec[`BIT_EVENT_FLAG]),
        .flag        (flag_vec[`BIT_EVENT_FLAG])
    );

    sticky_flag u_power_flag
    (
        .clk         (clk),
        .reset       (reset),
        .reset_value (rst_vec[`BIT_POWER_FLAG]),
        .set_pulse   (set_vec[`BIT_POWER_FLAG]),
        .clear_pulse (clr_vec[`BIT_POWER_FLAG]),
        .flag        (flag_vec[`BIT_POWER_FLAG])
    );

    // Busy bit is read-only live state
    assign flag_vec[`BIT_NVM_BUSY] = nvm_transfer_active;

    ////////////////////////////////////////////////////////////////////////////
    // Read path and registered outputs

    logic                 read_hit;
    status_pkg::byte_type rdata_reg;
    status_pkg::byte_type rdata_next;
    logic                 rvalid_reg;
    logic                 rvalid_next;
    status_pkg::byte_type flags_reg;
    status_pkg::byte_type flags_next;

    // Reads ignore protection entirely
    assign read_hit = reg_read && hit;

    ////////////////////////////////////////////////////////////////////////////
    // Read data: zero unless the status address is read

    always_comb
    begin
        rdata_next = `BYTE_ZERO;
        if (read_hit)
        begin
            rdata_next = flag_vec;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rdata_reg <= `BYTE_ZERO;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read strobe echo, answered for any address

    always_comb
    begin
        rvalid_next = reg_read;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rvalid_reg <= `FLAG_CLEAR;
        end
        else
        begin
            rvalid_reg <= rvalid_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status copy for the interrupt logic, one cycle late

    always_comb
    begin
        flags_next = flag_vec;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            flags_reg <= `BYTE_ZERO;
        end
        else
        begin
            flags_reg <= flags_next;
        end
    end

    assign reg_rdata  = rdata_reg;
    assign reg_rvalid = rvalid_reg;
    assign flags      = flags_reg;

endmodule

// >>> verilog/status_map.svh
`ifndef STATUS_MAP_SVH
`define STATUS_MAP_SVH

// Register offset on the host register port
`define EVENT_STATUS_FLAGS_ADDR 8'h0e

// Bit positions
`define BIT_NVM_BUSY      7
`define BIT_CLKOUT_FLAG   6
`define BIT_SWITCH_FLAG   5
`define BIT_UPDATE_FLAG   4
`define BIT_TIMER_FLAG    3
`define BIT_ALARM_FLAG    2
`define BIT_EVENT_FLAG    1
`define BIT_POWER_FLAG    0

// Values
`define FLAG_SET          1'h1
`define FLAG_CLEAR        1'h0
`define BYTE_ZERO         8'h00

`endif

// >>> verilog/status_pkg.sv
package status_pkg;

    typedef logic [7:0] byte_type;

endpackage

// >>> verilog/sticky_flag.sv
`timescale 1ns/1ps
`include "status_map.svh"

module sticky_flag
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic reset_value,
    // Event and clear
    input  wire logic set_pulse,
    input  wire logic clear_pulse,
    // State
    output logic      flag
);

    logic flag_reg;
    logic flag_next;

    always_comb
    begin
        flag_next = flag_reg;
        if (clear_pulse)
        begin
            flag_next = `FLAG_CLEAR;
        end
        // Set wins over a clear in the same cycle
        if (set_pulse)
        begin
            flag_next = `FLAG_SET;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            flag_reg <= reset_value;
        end
        else
        begin
            flag_reg <= flag_next;
        end
    end

    assign flag = flag_reg;

endmodule
